// *** rtl/ibx_target.sv ***
`timescale 1ns/1ps
`include "ibx_map.svh"
module ibx_target (
   input wire logic clock,
   input wire logic reset,
   input wire ibx_pkg::ibx_apb_req_t apbReq,
   output ibx_pkg::ibx_apb_rsp_t apbRsp,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic powerDown,
   input wire logic sleeping,
   output logic byteDoneIrq
);
   ibx_pkg::ibx_state_t r;
   ibx_pkg::ibx_state_t n;
   logic run, rise, fall, startEv, stopEv, rxDone, hit, matchNow, loadTx, enterAck, ackVal;
   logic setup, wrEv, mapped, goStrobe, byteEvt;
   logic [7:0] idx, wdat, rdVal, txByte;

   always_comb begin
      n = r;
      n.byteIrq = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.sclS1 = sclIn;
      n.sclS2 = r.sclS1;
      n.sdaS1 = sdaIn;
      n.sdaS2 = r.sdaS1;
      n.sclP = r.sclS2;
      n.sdaP = r.sdaS2;
      rxDone = 1'b0;
      hit = 1'b0;
      matchNow = 1'b0;
      loadTx = 1'b0;
      enterAck = 1'b0;
      ackVal = 1'b0;
      goStrobe = 1'b0;
      byteEvt = 1'b0;
      run = r.gate & r.enable;
      rise = run & r.sclS2 & ~r.sclP;
      fall = run & ~r.sclS2 & r.sclP;
      startEv = run & r.sclS2 & r.sclP & r.sdaP & ~r.sdaS2;
      stopEv = run & r.sclS2 & r.sclP & ~r.sdaP & r.sdaS2;
      txByte = r.shared ? (r.cpOver ? `IBX_INVALID_DATA : r.ram[r.cp]) : r.data;
      // register read mux
      idx = apbReq.paddr[9:2];
      wdat = apbReq.pwdata[7:0];
      mapped = (apbReq.paddr[11:10] == 2'h0);
      rdVal = 8'h00;
      case (idx)
         `IBX_IDX_XCFG: rdVal = {r.gate, 1'b0, r.refSel, r.refReq, r.noBc, 1'b0,
                                 r.shared, r.hwMatch};
         `IBX_IDX_XSTAT: rdVal = {r.bufActive, r.wrFlag, r.rdFlag, 2'h0, r.engaged,
                                  r.dir, r.active};
         `IBX_IDX_OWNADDR: rdVal = {1'b0, r.ownAddr};
         `IBX_IDX_BPCFG: rdVal = {r.rdIe, r.wrIe, r.wakeStretch, r.bp};
         `IBX_IDX_SCR: rdVal = {r.byteDone, 3'h0, r.addrFlag, 1'b0, r.ackSel, 1'b0};
         `IBX_IDX_DATA: rdVal = r.data;
         `IBX_IDX_BUF: rdVal = r.ram[r.cpuPtr];
         `IBX_IDX_CPUPTR: rdVal = {3'h0, r.cpuPtr};
         `IBX_IDX_BASECFG: rdVal = {7'h00, r.enable};
         default: mapped = 1'b0;
      endcase
      setup = apbReq.psel & ~apbReq.penable;
      wrEv = apbReq.psel & apbReq.penable & r.pready & apbReq.pwrite & mapped;
      if (setup) begin
         n.pready = 1'b1;
         n.pslverr = ~mapped;
         n.prdata = {24'h000000, rdVal};
      end
      // software writes first, so hardware sets below win
      if (wrEv) begin
         case (idx)
            `IBX_IDX_XCFG: begin
               n.gate = wdat[`IBX_XCFG_GATE];
               n.refSel = wdat[`IBX_XCFG_REFSEL];
               n.refReq = wdat[`IBX_XCFG_REFREQ];
               n.noBc = wdat[`IBX_XCFG_NOBC];
               n.shared = wdat[`IBX_XCFG_SHARED];
               n.hwMatch = wdat[`IBX_XCFG_HWMATCH];
            end
            `IBX_IDX_XSTAT: begin
               if (!wdat[`IBX_XSTAT_WR]) n.wrFlag = 1'b0;
               if (!wdat[`IBX_XSTAT_RD]) n.rdFlag = 1'b0;
            end
            `IBX_IDX_OWNADDR: n.ownAddr = wdat[6:0];
            `IBX_IDX_BPCFG: begin
               n.rdIe = wdat[`IBX_BP_RDIE];
               n.wrIe = wdat[`IBX_BP_WRIE];
               n.wakeStretch = wdat[`IBX_BP_WAKE];
            end
            `IBX_IDX_SCR: begin
               if (!wdat[`IBX_SCR_DONE]) n.byteDone = 1'b0;
               n.ackSel = wdat[`IBX_SCR_ACK];
               goStrobe = wdat[`IBX_SCR_GO];
            end
            `IBX_IDX_DATA: n.data = wdat;
            `IBX_IDX_BUF: begin
               // cpu side of the shared buffer
               n.ram[r.cpuPtr] = wdat;
               n.cpuPtr = r.cpuPtr + 5'h01;
            end
            `IBX_IDX_CPUPTR: n.cpuPtr = wdat[4:0];
            `IBX_IDX_BASECFG: n.enable = wdat[`IBX_BASE_ENABLE];
            default: n.enable = r.enable;
         endcase
      end
      if (run) begin
         // request outside a matched transaction engages at once
         if (r.refReq && !r.active) n.engaged = 1'b1;
         if (startEv) begin
            if (!r.refReq) n.engaged = 1'b0;
            n.phase = ibx_pkg::PH_RX;
            n.bitCnt = 4'h0;
            n.isAddr = 1'b1;
            n.bufActive = 1'b0;
            n.dir = 1'b0;
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
            n.holdWake = 1'b0;
         end else if (stopEv) begin
            n.phase = ibx_pkg::PH_IDLE;
            n.bufActive = 1'b0;
            n.active = 1'b0;
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
            n.holdWake = 1'b0;
            if (r.refReq && !r.refSel) n.engaged = 1'b1;
         end else begin
            case (r.phase)
               ibx_pkg::PH_RX: begin
                  if (rise && r.bitCnt < 4'h8) begin
                     n.shift = {r.shift[6:0], r.sdaS2};
                     n.bitCnt = r.bitCnt + 4'h1;
                  end
                  if (fall && r.bitCnt == 4'h8) rxDone = 1'b1;
               end
               ibx_pkg::PH_ACK: begin
                  if (fall) begin
                     n.sdaOe = 1'b0;
                     n.bitCnt = 4'h0;
                     if (!r.ackPending) n.phase = ibx_pkg::PH_IDLE;
                     else if (r.hostRd) loadTx = 1'b1;
                     else n.phase = ibx_pkg::PH_RX;
                  end
               end
               ibx_pkg::PH_HOLD: begin
                  if (goStrobe) begin
                     n.sclOe = 1'b0;
                     n.holdWake = 1'b0;
                     n.addrFlag = 1'b0;
                     if (r.holdTx) loadTx = 1'b1;
                     else if (r.isAddr && n.ackSel) matchNow = 1'b1;
                     else begin
                        enterAck = 1'b1;
                        ackVal = n.ackSel;
                     end
                  end
               end
               ibx_pkg::PH_TX: begin
                  if (rise) n.bitCnt = r.bitCnt + 4'h1;
                  if (fall && r.bitCnt < 4'h8) begin
                     n.shift = {r.shift[6:0], 1'b0};
                     n.sdaOe = ~r.shift[6];
                  end else if (fall) begin
                     n.sdaOe = 1'b0;
                     n.phase = ibx_pkg::PH_MACK;
                  end
               end
               ibx_pkg::PH_MACK: begin
                  if (rise) n.mastAck = ~r.sdaS2;
                  if (fall) begin
                     byteEvt = 1'b1;
                     if (!r.mastAck) begin
                        n.phase = ibx_pkg::PH_IDLE;
                        // host nack engages with byte-boundary select
                        if (r.refReq && r.refSel) n.engaged = 1'b1;
                     end else if (!r.shared) begin
                        n.phase = ibx_pkg::PH_HOLD;
                        n.holdTx = 1'b1;
                        n.sclOe = 1'b1;
                     end else loadTx = 1'b1;
                  end
               end
               default: n.phase = ibx_pkg::PH_IDLE;
            endcase
         end
         if (rxDone) begin
            byteEvt = 1'b1;
            n.isAddr = 1'b0;
            n.holdTx = 1'b0;
            if (r.isAddr) begin
               n.hostRd = r.shift[0];
               n.isAddr = 1'b1;
               hit = (r.shift[7:1] == r.ownAddr);
               if (r.shared && r.engaged) begin
                  // refused: nack, stay off the buffer
                  n.phase = ibx_pkg::PH_IDLE;
               end else if (r.shared && r.hwMatch) begin
                  if (!hit || (sleeping && !r.wakeStretch)) n.phase = ibx_pkg::PH_IDLE;
                  else if (sleeping) begin
                     n.phase = ibx_pkg::PH_HOLD;
                     n.holdWake = 1'b1;
                     n.sclOe = 1'b1;
                  end else matchNow = 1'b1;
               end else begin
                  n.addrFlag = 1'b1;
                  n.data = r.shift;
                  n.phase = ibx_pkg::PH_HOLD;
                  n.sclOe = 1'b1;
               end
            end else if (r.shared) begin
               enterAck = 1'b1;
               if (r.engaged) ackVal = 1'b0;
               else if (r.firstData) begin
                  n.firstData = 1'b0;
                  ackVal = (r.shift[7:5] == 3'h0);
                  if (ackVal) begin
                     n.bp = r.shift[4:0];
                     n.cp = r.shift[4:0];
                     n.cpOver = 1'b0;
                  end
               end else if (r.cpOver) ackVal = 1'b0;
               else begin
                  ackVal = 1'b1;
                  n.ram[r.cp] = r.shift;
                  if (r.cp == `IBX_RAM_LAST) n.cpOver = 1'b1;
                  else n.cp = r.cp + 5'h01;
               end
               if (r.refReq && r.refSel) n.engaged = 1'b1;
            end else begin
               n.data = r.shift;
               n.phase = ibx_pkg::PH_HOLD;
               n.sclOe = 1'b1;
            end
         end
         if (byteEvt) begin
            n.byteIrq = ~r.noBc & ((rxDone & r.isAddr) | ~r.byteDone);
            n.byteDone = 1'b1;
         end
         if (matchNow) begin
            enterAck = 1'b1;
            ackVal = 1'b1;
            n.isAddr = 1'b0;
            if (r.shared) begin
               n.bufActive = 1'b1;
               n.active = 1'b1;
               n.dir = n.hostRd;
               n.wrFlag = n.wrFlag | ~n.hostRd;
               n.rdFlag = n.rdFlag | n.hostRd;
               n.cp = r.bp;
               n.cpOver = 1'b0;
               n.firstData = ~n.hostRd;
            end
         end
         if (enterAck) begin
            n.phase = ibx_pkg::PH_ACK;
            n.ackPending = ackVal;
            n.sdaOe = ackVal;
            n.isAddr = 1'b0;
         end
         if (loadTx) begin
            n.holdTx = 1'b0;
            n.shift = txByte;
            n.sdaOe = ~txByte[7];
            n.bitCnt = 4'h0;
            n.phase = ibx_pkg::PH_TX;
            if (r.shared && !r.cpOver) begin
               if (r.cp == `IBX_RAM_LAST) n.cpOver = 1'b1;
               else n.cp = r.cp + 5'h01;
            end
         end
      end
      if (n.engaged) begin
         n.bufActive = 1'b0;
         n.wrFlag = 1'b0;
         n.rdFlag = 1'b0;
         n.dir = 1'b0;
         n.active = 1'b0;
      end
      if (powerDown) begin
         n.refReq = 1'b0;
         n.engaged = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.sclS1 <= 1'b1;
         r.sclS2 <= 1'b1;
         r.sclP <= 1'b1;
         r.sdaS1 <= 1'b1;
         r.sdaS2 <= 1'b1;
         r.sdaP <= 1'b1;
         r.phase <= ibx_pkg::PH_IDLE;
         {r.gate, r.refSel, r.refReq, r.noBc, r.shared, r.hwMatch} <= 6'h20;
         r.wrFlag <= 1'b1;
         r.ownAddr <= 7'h00;
      end else begin
         r <= n;
      end
   end

   assign apbRsp = '{pready: r.pready, pslverr: r.pslverr, prdata: r.prdata};
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = r.sclOe;
   assign sdaOe = r.sdaOe;
   assign byteDoneIrq = r.byteIrq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   noStall_shared_a: assert property (
      $rose(r.sclOe) |-> !(r.shared && r.hwMatch) || r.holdWake || !$past(r.shared))
      else $error("scl stalled in shared mode with matching");
   suppress_irq_a: assert property (
      byteDoneIrq |-> $past(!r.noBc))
      else $error("byte interrupt while suppressed");
   mask_irq_a: assert property (
      (byteEvt && !(rxDone && r.isAddr) && r.byteDone) |=> !byteDoneIrq)
      else $error("data byte interrupt with flag still set");
   pd_clear_a: assert property (
      powerDown |=> !r.refReq && !r.engaged)
      else $error("power-down left refusal set");
   idle_engage_a: assert property (
      (run && r.refReq && !r.active && !powerDown) |=> r.engaged)
      else $error("idle refusal did not engage");
   engaged_hide_a: assert property (
      r.engaged |-> !(r.bufActive | r.wrFlag | r.rdFlag | r.dir | r.active))
      else $error("status set while engaged");
   mismatch_idle_a: assert property (
      (rxDone && r.isAddr && r.shared && r.hwMatch && !hit) |=>
         r.phase == ibx_pkg::PH_IDLE && !r.sdaOe)
      else $error("mismatched address not refused");
   start_dir_a: assert property (
      startEv |=> !r.dir && !r.bufActive)
      else $error("start did not clear direction");
   compat_stall_a: assert property (
      (rxDone && !r.shared) |=> r.sclOe && r.phase == ibx_pkg::PH_HOLD)
      else $error("compatible mode did not stall");
   cp_step_a: assert property (
      $changed(r.cp) |-> r.cp == $past(r.cp) + 5'h01 || r.cp == r.bp)
      else $error("current pointer jumped");
   engaged_refuse_a: assert property (
      (rxDone && r.shared && r.engaged) |=> !r.sdaOe)
      else $error("refused transaction acknowledged");

   match_c: cover property (matchNow && r.shared);
   read_c: cover property (loadTx && r.shared);
   engage_c: cover property ($rose(r.engaged));
   hold_c: cover property (r.phase == ibx_pkg::PH_HOLD && goStrobe);
endmodule

// *** inc/ibx_map.svh ***
`ifndef IBX_MAP_SVH
`define IBX_MAP_SVH
// register indices; byte address is four times the index
`define IBX_IDX_XCFG 8'hC8
`define IBX_IDX_XSTAT 8'hC9
`define IBX_IDX_OWNADDR 8'hCA
`define IBX_IDX_BPCFG 8'hCB
`define IBX_IDX_SCR 8'hD0
`define IBX_IDX_DATA 8'hD1
`define IBX_IDX_BUF 8'hD2
`define IBX_IDX_CPUPTR 8'hD3
`define IBX_IDX_BASECFG 8'hD6
// reset values
`define IBX_XCFG_RST 8'h80
`define IBX_XSTAT_RST 8'h40
`define IBX_OWNADDR_RST 8'h00
`define IBX_BPCFG_RST 8'h00
// extended_config fields
`define IBX_XCFG_GATE 7
`define IBX_XCFG_REFSEL 5
`define IBX_XCFG_REFREQ 4
`define IBX_XCFG_NOBC 3
`define IBX_XCFG_SHARED 1
`define IBX_XCFG_HWMATCH 0
// extended_status fields
`define IBX_XSTAT_BUFACT 7
`define IBX_XSTAT_WR 6
`define IBX_XSTAT_RD 5
`define IBX_XSTAT_ENGAGED 2
`define IBX_XSTAT_DIR 1
`define IBX_XSTAT_ACTIVE 0
// host_base_pointer_config fields
`define IBX_BP_RDIE 7
`define IBX_BP_WRIE 6
`define IBX_BP_WAKE 5
// status_control_reg fields
`define IBX_SCR_DONE 7
`define IBX_SCR_ADDR 3
`define IBX_SCR_ACK 1
`define IBX_SCR_GO 0
`define IBX_BASE_ENABLE 0
// buffer limits
`define IBX_RAM_LAST 5'h1F
`define IBX_INVALID_DATA 8'hFF
`endif

// *** inc/ibx_pkg.sv ***
package ibx_pkg;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_RX = 3'b001,
      PH_ACK = 3'b010,
      PH_HOLD = 3'b011,
      PH_TX = 3'b100,
      PH_MACK = 3'b101
   } ibx_phase_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ibx_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ibx_apb_rsp_t;

   typedef struct packed {
      logic sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP;
      ibx_phase_t phase;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic isAddr, hostRd, firstData, ackPending, holdTx, holdWake, mastAck;
      logic gate, refSel, refReq, noBc, shared, hwMatch;
      logic bufActive, wrFlag, rdFlag, engaged, dir, active;
      logic [6:0] ownAddr;
      logic rdIe, wrIe, wakeStretch;
      logic [4:0] bp;
      logic [4:0] cp;
      logic cpOver;
      logic byteDone, addrFlag, ackSel;
      logic [7:0] data;
      logic [4:0] cpuPtr;
      logic enable;
      logic [31:0][7:0] ram;
      logic sclOe, sdaOe, byteIrq;
      logic pready, pslverr;
      logic [31:0] prdata;
   } ibx_state_t;
endpackage

// *** tb/ibx_host_model.sv ***
`timescale 1ns/1ps
module ibx_host_model (
   input wire logic clock,
   input wire logic sclWire,
   input wire logic sdaWire,
   output logic sclLow,
   output logic sdaLow
);
   localparam int Q = 8;
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   task automatic waitq();
      repeat (Q) @(posedge clock);
   endtask
   task automatic sclRise();
      int n;
      n = 0;
      sclLow <= 1'b0;
      @(posedge clock);
      while (sclWire !== 1'b1 && n < 4000) begin
         @(posedge clock);
         n++;
      end
      waitq();
   endtask
   task automatic bitCycle(input logic b, output logic s);
      sdaLow <= ~b;
      waitq();
      sclRise();
      s = sdaWire;
      sclLow <= 1'b1;
      waitq();
   endtask
   // start or repeated start
   task automatic start();
      sdaLow <= 1'b0;
      waitq();
      sclRise();
      sdaLow <= 1'b1;
      waitq();
      sclLow <= 1'b1;
      waitq();
   endtask
   task automatic stop();
      sdaLow <= 1'b1;
      waitq();
      sclRise();
      sdaLow <= 1'b0;
      waitq();
   endtask
   task automatic writeByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(d[i], s);
      end
      bitCycle(1'b1, s);
      ack = ~s;
   endtask
   task automatic readByte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(1'b1, s);
         d[i] = s;
      end
      bitCycle(~mack, s);
   endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "ibx_map.svh"
module tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   ibx_pkg::ibx_apb_req_t apbReq = '0;
   ibx_pkg::ibx_apb_rsp_t apbRsp;
   logic powerDown = 1'b0;
   logic sleeping = 1'b0;
   logic sclOe, sdaOe, byteDoneIrq, sclLow, sdaLow, sclWire, sdaWire;
   logic sclOut, sdaOut;
   int fails = 0;
   int num_checks = 0;
   int irqCnt = 0;
   int irqMark = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;
   logic ack;
   logic [7:0] b;
   always #4 clock = ~clock;
   assign sclWire = ~(sclLow | (sclOe & ~sclOut));
   assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
   ibx_target dut_u (.clock(clock), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
      .sclIn(sclWire), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .powerDown(powerDown), .sleeping(sleeping), .byteDoneIrq(byteDoneIrq));
   ibx_host_model host_u (.clock(clock), .sclWire(sclWire), .sdaWire(sdaWire),
      .sclLow(sclLow), .sdaLow(sdaLow));
   task automatic complete_run();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (byteDoneIrq === 1'b1) begin
         irqCnt <= irqCnt + 1;
      end
      if (cycles == 40000) begin
         fails++;
         complete_run();
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      apbReq <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h0, wd}};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 100);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      if (n >= 100) begin
         check("pready", 1'b1, 1'b0);
      end
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
      apb(1'b0, idx, 8'h00);
      check($sformatf("reg %h", idx), {24'h0, exp & m}, rd & {24'h0, m});
   endtask
   task automatic xfer(input logic [7:0] d, input logic exp);
      host_u.writeByte(d, ack);
      check($sformatf("ack of %h", d), exp, ack);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      rdChk(`IBX_IDX_XCFG, `IBX_XCFG_RST, 8'hFF);
      rdChk(`IBX_IDX_XSTAT, 8'h40, 8'hFF);
      rdChk(`IBX_IDX_OWNADDR, 8'h00, 8'hFF);
      rdChk(`IBX_IDX_BPCFG, 8'h00, 8'hFF);
      apb(1'b0, 8'h10, 8'h00);
      check("unmapped err", 1'b1, err);
      apb(1'b1, `IBX_IDX_XCFG, 8'h83);
      apb(1'b1, `IBX_IDX_BASECFG, 8'h01);
      apb(1'b1, `IBX_IDX_OWNADDR, 8'h2A);
      host_u.start();
      xfer(8'h54, 1'b1);
      xfer(8'h04, 1'b1);
      xfer(8'hA5, 1'b1);
      xfer(8'h3C, 1'b1);
      rdChk(`IBX_IDX_XSTAT, 8'hC1, 8'hFF);
      host_u.stop();
      rdChk(`IBX_IDX_XSTAT, 8'h40, 8'hFF);
      rdChk(`IBX_IDX_BPCFG, 8'h04, 8'h1F);
      apb(1'b1, `IBX_IDX_CPUPTR, 8'h05);
      rdChk(`IBX_IDX_BUF, 8'h3C, 8'hFF);
      check("irq seen", 1'b1, irqCnt > 0);
      apb(1'b1, `IBX_IDX_XSTAT, 8'h00);
      host_u.start();
      xfer(8'h55, 1'b1);
      rdChk(`IBX_IDX_XSTAT, 8'hA3, 8'hFF);
      host_u.readByte(1'b1, b);
      check("read 0", 8'hA5, b);
      host_u.readByte(1'b0, b);
      check("read 1", 8'h3C, b);
      host_u.stop();
      host_u.start();
      xfer(8'hC0, 1'b0);
      host_u.stop();
      host_u.start();
      xfer(8'h54, 1'b1);
      xfer(8'h20, 1'b0);
      host_u.stop();
      rdChk(`IBX_IDX_BPCFG, 8'h04, 8'h1F);
      host_u.start();
      xfer(8'h54, 1'b1);
      xfer(8'h1E, 1'b1);
      xfer(8'h11, 1'b1);
      xfer(8'h22, 1'b1);
      xfer(8'h33, 1'b0);
      host_u.stop();
      apb(1'b1, `IBX_IDX_CPUPTR, 8'h1F);
      rdChk(`IBX_IDX_BUF, 8'h22, 8'hFF);
      apb(1'b1, `IBX_IDX_XCFG, 8'h8B);
      irqMark = irqCnt;
      host_u.start();
      xfer(8'h54, 1'b1);
      xfer(8'h00, 1'b1);
      host_u.stop();
      check("no irq", irqMark, irqCnt);
      apb(1'b1, `IBX_IDX_XCFG, 8'hA3);
      apb(1'b1, `IBX_IDX_XCFG, 8'hB3);
      rdChk(`IBX_IDX_XSTAT, 8'h04, 8'hFF);
      host_u.start();
      xfer(8'h54, 1'b0);
      host_u.stop();
      @(posedge clock);
      powerDown <= 1'b1;
      @(posedge clock);
      powerDown <= 1'b0;
      rdChk(`IBX_IDX_XCFG, 8'hA3, 8'hFF);
      rdChk(`IBX_IDX_XSTAT, 8'h00, 8'h04);
      apb(1'b1, `IBX_IDX_XCFG, 8'h82);
      fork
         begin
            host_u.start();
            xfer(8'h54, 1'b1);
         end
         begin
            repeat (350) @(posedge clock);
            check("stall", 1'b1, sclOe);
            rdChk(`IBX_IDX_SCR, 8'h08, 8'h08);
            rdChk(`IBX_IDX_DATA, 8'h54, 8'hFF);
            apb(1'b1, `IBX_IDX_SCR, 8'h03);
         end
      join
      xfer(8'h06, 1'b1);
      host_u.stop();
      apb(1'b1, `IBX_IDX_XCFG, 8'h83);
      apb(1'b1, `IBX_IDX_BPCFG, 8'hE0);
      rdChk(`IBX_IDX_BPCFG, 8'hE0, 8'hE0);
      sleeping <= 1'b1;
      fork
         begin
            host_u.start();
            xfer(8'h54, 1'b1);
         end
         begin
            repeat (350) @(posedge clock);
            check("wake stall", 1'b1, sclOe);
            sleeping <= 1'b0;
            apb(1'b1, `IBX_IDX_SCR, 8'h03);
         end
      join
      xfer(8'h07, 1'b1);
      host_u.stop();
      apb(1'b1, `IBX_IDX_BPCFG, 8'h00);
      sleeping <= 1'b1;
      host_u.start();
      xfer(8'h54, 1'b0);
      host_u.stop();
      sleeping <= 1'b0;
      host_u.start();
      xfer(8'h54, 1'b1);
      xfer(8'h00, 1'b1);
      apb(1'b1, `IBX_IDX_XCFG, 8'h93);
      xfer(8'h99, 1'b1);
      rdChk(`IBX_IDX_XSTAT, 8'h00, 8'h04);
      host_u.stop();
      rdChk(`IBX_IDX_XSTAT, 8'h04, 8'h04);
      apb(1'b1, `IBX_IDX_XCFG, 8'h83);
      rdChk(`IBX_IDX_XSTAT, 8'h04, 8'h04);
      host_u.start();
      xfer(8'h54, 1'b1);
      host_u.stop();
      apb(1'b1, `IBX_IDX_XCFG, 8'hA3);
      host_u.start();
      xfer(8'h55, 1'b1);
      apb(1'b1, `IBX_IDX_XCFG, 8'hB3);
      rdChk(`IBX_IDX_XSTAT, 8'h00, 8'h04);
      host_u.readByte(1'b0, b);
      check("read base", 8'h99, b);
      rdChk(`IBX_IDX_XSTAT, 8'h04, 8'h04);
      host_u.stop();
      apb(1'b1, `IBX_IDX_XCFG, 8'h80);
      fork
         begin
            host_u.start();
            xfer(8'h54, 1'b1);
         end
         begin
            repeat (350) @(posedge clock);
            check("compat stall", 1'b1, sclOe);
            rdChk(`IBX_IDX_DATA, 8'h54, 8'hFF);
            apb(1'b1, `IBX_IDX_SCR, 8'h03);
         end
      join
      fork
         xfer(8'h5A, 1'b1);
         begin
            repeat (240) @(posedge clock);
            check("data stall", 1'b1, sclOe);
            rdChk(`IBX_IDX_DATA, 8'h5A, 8'hFF);
            apb(1'b1, `IBX_IDX_SCR, 8'h03);
         end
      join
      host_u.stop();
      complete_run();
   end
endmodule
